// file: dv/lpwg_checker.sv
// concurrent checks on the wake-up gate ports
`timescale 1ns/1ps
module lpwg_checker (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cpuSleep,
    input wire logic usbNeedClk,
    input wire logic extRstPinN,
    input wire logic rtc_alarm_irq,
    input wire logic rtcWake,
    input wire logic deepSleepOn,
    input wire logic powerDownOn,
    input wire logic clocksOn,
    input wire logic cpuResume,
    input wire logic chipResetReq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    chk_sleep_entry: assert property ($rose(deepSleepOn) |-> !clocksOn && $past(cpuSleep))
        else $error("sleep entry wrong");
    chk_dpd_entry: assert property ($rose(powerDownOn) |-> !clocksOn && !deepSleepOn)
        else $error("power-down entry wrong");
    chk_usb_wake: assert property (deepSleepOn && !clocksOn && usbNeedClk |-> ##[1:3] clocksOn)
        else $error("usb request did not wake");
    chk_restore_time: assert property ($rose(clocksOn) && $past(deepSleepOn) |->
        !cpuResume[*8] ##[1:16] (cpuResume || chipResetReq))
        else $error("restore time wrong");
    chk_reset_len: assert property ($rose(chipResetReq) |-> ##99 chipResetReq ##1 !chipResetReq)
        else $error("reset pulse length wrong");
    chk_resume_pulse: assert property (cpuResume |=> !cpuResume && !deepSleepOn)
        else $error("resume pulse wrong");
    chk_dpd_hold: assert property ((powerDownOn && extRstPinN && !rtc_alarm_irq && !rtcWake)[*6]
        |=> powerDownOn)
        else $error("power-down left without cause");
    chk_pin_reset: assert property ($fell(extRstPinN) && powerDownOn |-> ##[2:6] chipResetReq)
        else $error("reset pin ignored");
endmodule

// file: dv/lpwg_partner.sv
// far-side model: usb and wake-request peripherals plus the rtc domain
`timescale 1ns/1ps
module lpwg_partner (
    input  wire logic       ref_clk,
    input  wire logic [3:0] fire,
    output logic            usbNeedClk,
    output logic            hw_wake_request,
    output wire logic       rtc_alarm_irq,
    output wire logic       rtcWake
);
    // requests follow the command one cycle late, as slow peripherals do
    always @(posedge ref_clk) begin
        usbNeedClk <= fire[0];
        hw_wake_request     <= fire[1];
    end
    // rtc events come from their own domain, off the main clock phase
    assign #3 rtc_alarm_irq = fire[2];
    assign #3 rtcWake  = fire[3];
endmodule

// file: dv/lpwg_wake_gate_tb.sv
// bench for the wake-up gate: table of wake cases, then hand-written cases
`timescale 1ns/1ps
module lpwg_wake_gate_tb;
    logic        ref_clk = 0, sys_rst = 1, cpuSleep = 0, extRstPinN = 1;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, pinIrq;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, bodIrq, bodRst, wdtIrq, wdtRst, wdtFeed, rtc_alarm_irq, rtcWake;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, ex, got;
    logic [9:0]  coreIrqEn = 10'h3ff;
    logic        rtcCountWrite, rtcWakeWrite, utickIrq, utickRunning, i2cIrq, i2cSlave, spiIrq;
    logic        spiSlave, usartIrq, usartSlave, usart32k, usbNeedClk, hw_wake_request, deepSleepOn;
    logic        powerDownOn, clocksOn, cpuResume, chipResetReq, wakeIrq;
    logic [27:0] ev = 0, e;
    logic [8:0]  s0;
    logic [11:0] cf;
    int          errors = 0, checks_done = 0, cyc = 0, n;
    // outcome (0 none, 1 resume, 2 reset), events, start-enable 0, configuration
    logic [50:0] rows [16] = '{
        {2'h1, 28'h0000010, 9'h001, 12'h000}, {2'h0, 28'h0000010, 9'h000, 12'h000},
        {2'h2, 28'h0001000, 9'h000, 12'h004}, {2'h0, 28'h0001000, 9'h000, 12'h000},
        {2'h1, 28'h0002000, 9'h010, 12'h003}, {2'h0, 28'h0002000, 9'h010, 12'h002},
        {2'h1, 28'h000c000, 9'h000, 12'h000}, {2'h0, 28'h0004000, 9'h000, 12'h000},
        {2'h1, 28'h8040000, 9'h000, 12'h000}, {2'h1, 28'h0000001, 9'h000, 12'h000},
        {2'h1, 28'h0000002, 9'h000, 12'h000}, {2'h1, 28'h6000000, 9'h100, 12'h808},
        {2'h1, 28'h0500000, 9'h020, 12'h078}, {2'h2, 28'h0600000, 9'h000, 12'h0a8},
        {2'h1, 28'h0800004, 9'h040, 12'h500}, {2'h1, 28'h1000008, 9'h080, 12'h000}};
    // event vector fans out to the peripheral inputs
    assign {usart32k, utickRunning, utickIrq, rtcWakeWrite, rtcCountWrite, wdtFeed, wdtRst, wdtIrq,
        usartSlave, usartIrq, spiSlave, spiIrq, i2cSlave, i2cIrq, bodIrq, bodRst, pinIrq} = ev[27:4];
    lpwg_wake_gate dut (.*);
    lpwg_partner peer (.ref_clk, .fire(ev[3:0]), .usbNeedClk, .hw_wake_request, .rtc_alarm_irq, .rtcWake);
    // clock and hang limit
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc > 8000) begin errors++; conclude(); end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin s_axi_bready <= 0; r = s_axi_bresp; end
        end while (!s_axi_bvalid);
    endtask
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0; d = s_axi_rdata; r = s_axi_rresp;
    endtask
    task automatic till(ref logic s);
        for (int k = 0; k < 150 && s !== 1'b1; k++) @(posedge ref_clk);
    endtask
    task irq(input logic v);
        repeat (2) @(posedge ref_clk);
        chk(wakeIrq, v);
    endtask
    task rst();
        @(posedge ref_clk); sys_rst <= 1; @(posedge ref_clk); sys_rst <= 0;
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 0;
        foreach (rows[i]) begin
            {ex, e, s0, cf} = rows[i];
            wr(8'h0c, 32'(cf)); wr(8'h04, 32'(s0)); wr(8'h1c, 32'hfff); wr(8'h00, 32'h1);
            cpuSleep <= 1; till(deepSleepOn); ev <= e; got = 0;
            for (n = 0; n < 60 && got == 0; n++) begin
                @(posedge ref_clk);
                if (cpuResume) got = 1;
                if (chipResetReq) got = 2;
            end
            ev <= 0; cpuSleep <= 0;
            chk(got, ex);
            if (ex == 1) begin
                irq(1); wr(8'h1c, 0); irq(0); wr(8'h18, 32'hfff); wr(8'h1c, 32'hfff); irq(0);
            end
            $display("row %0d done", i);
            rst();
        end
        rd(8'h14); chk(d, 0); rd(8'h20); chk(r, 2'h2);
        wr(8'h20, 0); chk(r, 2'h2); chk(clocksOn, 1);
        $display("register test done");
        wr(8'h0c, 32'h100); ev <= 28'h0800000; @(posedge ref_clk); ev <= 0;
        wr(8'h00, 32'h2); cpuSleep <= 1; till(powerDownOn); ev <= 28'h1;
        repeat (40) @(posedge ref_clk);
        chk(powerDownOn, 1); ev <= 28'h4; till(chipResetReq);
        chk(chipResetReq, 1); ev <= 0; cpuSleep <= 0; rst();
        wr(8'h00, 32'h2); cpuSleep <= 1; till(powerDownOn); extRstPinN <= 0;
        repeat (4) @(posedge ref_clk);
        extRstPinN <= 1; till(chipResetReq); chk(chipResetReq, 1);
        $display("power-down test done");
        conclude();
    end
endmodule
bind lpwg_wake_gate lpwg_checker chk_i (.ref_clk, .sys_rst, .cpuSleep, .usbNeedClk, .extRstPinN,
    .rtc_alarm_irq, .rtcWake, .deepSleepOn, .powerDownOn, .clocksOn, .cpuResume, .chipResetReq);

// file: logic/lpwg_axil.v
// axi4-lite slave front end for the wake-up gate registers
`timescale 1ns/1ps
module lpwg_axil (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        regWrEn,
    output wire [7:0]  regWrAddr,
    output wire [31:0] regWrData,
    output wire [3:0]  regWrStrb,
    input  wire        regWrOk,
    output wire [7:0]  regRdAddr,
    input  wire [31:0] regRdData,
    input  wire        regRdOk
);
    reg        awRdyQ;
    reg [7:0]  awAddrQ;
    reg        wRdyQ;
    reg [31:0] wDataQ;
    reg [3:0]  wStrbQ;
    reg        bValidQ;
    reg [1:0]  bRespQ;
    reg        arRdyQ;
    reg        rValidQ;
    reg [31:0] rDataQ;
    reg [1:0]  rRespQ;

    // commit once both halves are held and no response is pending
    assign regWrEn   = ~awRdyQ & ~wRdyQ & ~bValidQ;
    assign regWrAddr = awAddrQ;
    assign regWrData = wDataQ;
    assign regWrStrb = wStrbQ;
    assign regRdAddr = s_axi_araddr;

    // write channels: address and data taken in either order
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            awRdyQ  <= 1'b1;
            awAddrQ <= 8'h00;
            wRdyQ   <= 1'b1;
            wDataQ  <= 32'h00000000;
            wStrbQ  <= 4'h0;
            bValidQ <= 1'b0;
            bRespQ  <= 2'h0;
        end else begin
            if (s_axi_awvalid && awRdyQ) begin
                awRdyQ  <= 1'b0;
                awAddrQ <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wRdyQ) begin
                wRdyQ  <= 1'b0;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (regWrEn) begin
                bValidQ <= 1'b1;
                bRespQ  <= regWrOk ? 2'h0 : 2'h2; // slverr on unmapped
            end
            if (bValidQ && s_axi_bready) begin
                bValidQ <= 1'b0;
                awRdyQ  <= 1'b1;
                wRdyQ   <= 1'b1;
            end
        end
    end

    // read channel: data captured on the address handshake
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            arRdyQ  <= 1'b1;
            rValidQ <= 1'b0;
            rDataQ  <= 32'h00000000;
            rRespQ  <= 2'h0;
        end else begin
            if (s_axi_arvalid && arRdyQ) begin
                arRdyQ  <= 1'b0;
                rValidQ <= 1'b1;
                rDataQ  <= regRdOk ? regRdData : 32'h00000000;
                rRespQ  <= regRdOk ? 2'h0 : 2'h2;
            end
            if (rValidQ && s_axi_rready) begin
                rValidQ <= 1'b0;
                arRdyQ  <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awRdyQ;
    assign s_axi_wready  = wRdyQ;
    assign s_axi_bvalid  = bValidQ;
    assign s_axi_bresp   = bRespQ;
    assign s_axi_arready = arRdyQ;
    assign s_axi_rvalid  = rValidQ;
    assign s_axi_rdata   = rDataQ;
    assign s_axi_rresp   = rRespQ;
endmodule

// file: logic/lpwg_regs.vh
// register offsets, field positions, reset values and timing counts of the wake-up gate
`ifndef LPWG_REGS_VH
`define LPWG_REGS_VH

// byte offsets on the register bus
`define LPWG_OFF_CTRL       8'h00
`define LPWG_OFF_START0     8'h04
`define LPWG_OFF_START1     8'h08
`define LPWG_OFF_CFG        8'h0c
`define LPWG_OFF_STATE      8'h10
`define LPWG_OFF_WSTAT      8'h14
`define LPWG_OFF_WCLR       8'h18
`define LPWG_OFF_WIEN       8'h1c

// low-power mode request codes held in the control register
`define LPWG_MODE_NONE      2'h0
`define LPWG_MODE_DSLEEP    2'h1
`define LPWG_MODE_DPD       2'h2

// start_enable_reg0 fields (pins 0..3 in bits 3:0)
`define LPWG_S0_BOD         4
`define LPWG_S0_WDT         5
`define LPWG_S0_ALARM       6
`define LPWG_S0_RTCWAKE     7
`define LPWG_S0_MICROTICK_TIMER       8

// configuration register fields
`define LPWG_CF_BODRUN      0
`define LPWG_CF_BODIRQ      1
`define LPWG_CF_BODRST      2
`define LPWG_CF_WOSCPWR     3
`define LPWG_CF_WOSCRUN     4
`define LPWG_CF_WDTEN       5
`define LPWG_CF_WDTIRQ      6
`define LPWG_CF_WDTRST      7
`define LPWG_CF_RTC1HZ      8
`define LPWG_CF_RTC1KHZ     9
`define LPWG_CF_RTCBUS      10
`define LPWG_CF_UTICKCLK    11

// wake cause bits (status, clear and enable share this layout)
`define LPWG_WS_PIN         0
`define LPWG_WS_BODIRQ      1
`define LPWG_WS_BODRST      2
`define LPWG_WS_WDTIRQ      3
`define LPWG_WS_WDTRST      4
`define LPWG_WS_ALARM       5
`define LPWG_WS_RTCWAKE     6
`define LPWG_WS_MICROTICK_TIMER       7
`define LPWG_WS_SERIAL      8
`define LPWG_WS_USB         9
`define LPWG_WS_HW_WAKE_REQUEST      10
`define LPWG_WS_RSTPIN      11
`define LPWG_WS_RESET_MASK  12'h814

// reset values
`define LPWG_RST_CTRL       2'h0
`define LPWG_RST_START0     9'h000
`define LPWG_RST_START1     4'h0
`define LPWG_RST_CFG        12'h000
`define LPWG_RST_WSTAT      12'h000
`define LPWG_RST_WIEN       12'h000

// timing: clock period, clock restore time and reset pulse time
`define LPWG_CLK_NS         10
`define LPWG_RESTORE_NS     200
`define LPWG_RESET_NS       1000
`define LPWG_RESTORE_CYC    8'h14 // restore time in clock cycles, counter width
`define LPWG_RESET_CYC      8'h64 // reset pulse in clock cycles, counter width

`endif

// file: logic/lpwg_sync.v
// two-flop synchronisers for inputs from other clock domains
`timescale 1ns/1ps
module lpwg_sync #(
    parameter WIDTH = 3
) (
    input  wire             ref_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] metaQ;
    reg [WIDTH-1:0] syncQ;

    // first stage feeds only the second stage
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            metaQ <= {WIDTH{1'b0}};
            syncQ <= {WIDTH{1'b0}};
        end else begin
            metaQ <= asyncIn;
            syncQ <= metaQ;
        end
    end

    assign syncOut = syncQ;
endmodule

// file: logic/lpwg_wake_gate.v
// deep-sleep and deep power-down wake-up gating with power sequencing
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "lpwg_regs.vh"
module lpwg_wake_gate (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        cpuSleep,
    input  wire [9:0]  coreIrqEn,
    input  wire [7:0]  pinIrq,
    input  wire        bodIrq,
    input  wire        bodRst,
    input  wire        wdtIrq,
    input  wire        wdtRst,
    input  wire        wdtFeed,
    input  wire        rtc_alarm_irq,
    input  wire        rtcWake,
    input  wire        rtcCountWrite,
    input  wire        rtcWakeWrite,
    input  wire        utickIrq,
    input  wire        utickRunning,
    input  wire        i2cIrq,
    input  wire        i2cSlave,
    input  wire        spiIrq,
    input  wire        spiSlave,
    input  wire        usartIrq,
    input  wire        usartSlave,
    input  wire        usart32k,
    input  wire        usbNeedClk,
    input  wire        hw_wake_request,
    input  wire        extRstPinN,
    output wire        deepSleepOn,
    output wire        powerDownOn,
    output wire        clocksOn,
    output wire        cpuResume,
    output wire        chipResetReq,
    output wire        wakeIrq
);
    localparam [2:0] ST_ACTIVE  = 3'h0;
    localparam [2:0] ST_DSLEEP  = 3'h1;
    localparam [2:0] ST_DPD     = 3'h2;
    localparam [2:0] ST_RESTORE = 3'h3;
    localparam [2:0] ST_RESET   = 3'h4;
    localparam [7:0] RESTORE_CYC = `LPWG_RESTORE_CYC;
    localparam [7:0] RESET_CYC   = `LPWG_RESET_CYC;

    // byte-lane merge of a bus write into a register word
    function [31:0] mergeStrb;
        input [31:0] oldV;
        input [31:0] newV;
        input [3:0]  strb;
        begin
            mergeStrb = {strb[3] ? newV[31:24] : oldV[31:24],
                         strb[2] ? newV[23:16] : oldV[23:16],
                         strb[1] ? newV[15:8]  : oldV[15:8],
                         strb[0] ? newV[7:0]   : oldV[7:0]};
        end
    endfunction

    // sticky flag update, a set beats a clear in the same cycle
    function sticky;
        input q;
        input setV;
        input clrV;
        begin
            sticky = setV | (q & ~clrV);
        end
    endfunction

    // mapped register offsets
    function addrOk;
        input [7:0] a;
        begin
            addrOk = (a == `LPWG_OFF_CTRL)  || (a == `LPWG_OFF_START0) ||
                     (a == `LPWG_OFF_START1) || (a == `LPWG_OFF_CFG)   ||
                     (a == `LPWG_OFF_STATE)  || (a == `LPWG_OFF_WSTAT) ||
                     (a == `LPWG_OFF_WCLR)   || (a == `LPWG_OFF_WIEN);
        end
    endfunction

    reg  [1:0]  ctrlQ;
    reg  [8:0]  start0Q;
    reg  [3:0]  start1Q;
    reg  [11:0] cfgQ;
    reg  [11:0] wStatQ;
    reg  [11:0] wIenQ;
    reg  [2:0]  stateQ;
    reg  [2:0]  stateD;
    reg  [7:0]  cntQ;
    reg  [7:0]  cntD;
    reg         wdtFedQ;
    reg         rtcCntArmQ;
    reg         rtcWakeArmQ;
    reg         deepSleepOnQ;
    reg         powerDownOnQ;
    reg         clocksOnQ;
    reg         cpuResumeQ;
    reg         chipResetReqQ;
    reg         wakeIrqQ;
    reg  [11:0] causeSet;
    reg  [31:0] rdData;
    wire        regWrEn;
    wire [7:0]  regWrAddr;
    wire [31:0] regWrData;
    wire [3:0]  regWrStrb;
    wire [7:0]  regRdAddr;
    wire [2:0]  asyncSync;
    wire [31:0] wrWord;
    wire [31:0] clrWord;

    // bus front end
    lpwg_axil uAxil (
        .ref_clk       (ref_clk),
        .sys_rst       (sys_rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regWrEn       (regWrEn),
        .regWrAddr     (regWrAddr),
        .regWrData     (regWrData),
        .regWrStrb     (regWrStrb),
        .regWrOk       (addrOk(regWrAddr)),
        .regRdAddr     (regRdAddr),
        .regRdData     (rdData),
        .regRdOk       (addrOk(regRdAddr))
    );

    // rtc events and the reset pin come from other domains
    lpwg_sync #(
        .WIDTH (3)
    ) uSync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn ({rtcWake, rtc_alarm_irq, ~extRstPinN}),
        .syncOut (asyncSync)
    );

    wire rstPinHit = asyncSync[0];
    wire rtcAlarmS = asyncSync[1];
    wire rtcWakeS  = asyncSync[2];
    wire inDs      = (stateQ == ST_DSLEEP);
    wire inDpd     = (stateQ == ST_DPD);

    // deep-sleep qualified sources
    wire dsPin     = |(pinIrq & coreIrqEn[7:0] & {start1Q, start0Q[3:0]});
    wire dsBodIrq  = bodIrq & cfgQ[`LPWG_CF_BODRUN] & cfgQ[`LPWG_CF_BODIRQ]
                   & coreIrqEn[8] & start0Q[`LPWG_S0_BOD];
    wire dsBodRst  = bodRst & cfgQ[`LPWG_CF_BODRST];
    wire dsWdtIrq  = wdtIrq & cfgQ[`LPWG_CF_WOSCPWR] & cfgQ[`LPWG_CF_WOSCRUN]
                   & cfgQ[`LPWG_CF_WDTEN] & wdtFedQ & cfgQ[`LPWG_CF_WDTIRQ]
                   & coreIrqEn[9] & start0Q[`LPWG_S0_WDT];
    wire dsWdtRst  = wdtRst & cfgQ[`LPWG_CF_WOSCPWR] & cfgQ[`LPWG_CF_WDTEN]
                   & cfgQ[`LPWG_CF_WDTRST] & wdtFedQ;
    wire dsAlarm   = rtcAlarmS & cfgQ[`LPWG_CF_RTC1HZ] & cfgQ[`LPWG_CF_RTCBUS]
                   & rtcCntArmQ & start0Q[`LPWG_S0_ALARM];
    wire dsRtcWake = rtcWakeS & rtcWakeArmQ & start0Q[`LPWG_S0_RTCWAKE];
    wire dsUtick   = utickIrq & cfgQ[`LPWG_CF_WOSCPWR] & cfgQ[`LPWG_CF_UTICKCLK]
                   & utickRunning & start0Q[`LPWG_S0_MICROTICK_TIMER];
    wire dsSerial  = (i2cIrq & i2cSlave) | (spiIrq & spiSlave)
                   | (usartIrq & (usartSlave | usart32k));

    // deep power-down qualified sources
    wire dpdAlarm   = rtcAlarmS & cfgQ[`LPWG_CF_RTC1HZ] & rtcCntArmQ;
    wire dpdRtcWake = rtcWakeS & cfgQ[`LPWG_CF_RTC1HZ] & cfgQ[`LPWG_CF_RTC1KHZ]
                    & cfgQ[`LPWG_CF_RTCBUS] & rtcWakeArmQ;

    // wake cause vector for the current state
    always @* begin
        causeSet = 12'h000;
        if (inDs) begin
            causeSet[`LPWG_WS_PIN]     = dsPin;
            causeSet[`LPWG_WS_BODIRQ]  = dsBodIrq;
            causeSet[`LPWG_WS_BODRST]  = dsBodRst;
            causeSet[`LPWG_WS_WDTIRQ]  = dsWdtIrq;
            causeSet[`LPWG_WS_WDTRST]  = dsWdtRst;
            causeSet[`LPWG_WS_ALARM]   = dsAlarm;
            causeSet[`LPWG_WS_RTCWAKE] = dsRtcWake;
            causeSet[`LPWG_WS_MICROTICK_TIMER]   = dsUtick;
            causeSet[`LPWG_WS_SERIAL]  = dsSerial;
            causeSet[`LPWG_WS_USB]     = usbNeedClk;
            causeSet[`LPWG_WS_HW_WAKE_REQUEST]  = hw_wake_request;
        end
        if (inDpd) begin
            causeSet[`LPWG_WS_ALARM]   = dpdAlarm;
            causeSet[`LPWG_WS_RTCWAKE] = dpdRtcWake;
        end
        causeSet[`LPWG_WS_RSTPIN] = rstPinHit;
    end

    // every cause out of power-down is reset-type, in deep-sleep only some are
    wire [11:0] rstMask    = inDpd ? 12'hfff : `LPWG_WS_RESET_MASK;
    wire        wakeReset  = |(causeSet & rstMask);
    wire        wakeResume = |(causeSet & ~rstMask);

    // power sequencing next state
    always @* begin
        stateD = stateQ;
        cntD   = cntQ;
        case (stateQ)
            ST_ACTIVE: begin
                if (wakeReset) begin
                    stateD = ST_RESET;
                    cntD   = RESET_CYC - 8'h01;
                end else if (cpuSleep && ctrlQ == `LPWG_MODE_DSLEEP) begin
                    stateD = ST_DSLEEP;
                end else if (cpuSleep && ctrlQ == `LPWG_MODE_DPD) begin
                    stateD = ST_DPD;
                end
            end
            ST_DSLEEP, ST_DPD: begin
                if (wakeReset) begin
                    stateD = ST_RESET;
                    cntD   = RESET_CYC - 8'h01;
                end else if (wakeResume) begin
                    stateD = ST_RESTORE;
                    cntD   = RESTORE_CYC - 8'h01;
                end
            end
            ST_RESTORE: begin
                if (wakeReset) begin
                    stateD = ST_RESET;
                    cntD   = RESET_CYC - 8'h01;
                end else if (cntQ == 8'h00) begin
                    stateD = ST_ACTIVE;
                end else begin
                    cntD = cntQ - 8'h01;
                end
            end
            ST_RESET: begin
                if (cntQ == 8'h00) begin
                    stateD = ST_ACTIVE;
                end else begin
                    cntD = cntQ - 8'h01;
                end
            end
            default: begin
                stateD = ST_ACTIVE;
                cntD   = 8'h00;
            end
        endcase
    end

    // state and registered power outputs
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateQ        <= ST_ACTIVE;
            cntQ          <= 8'h00;
            deepSleepOnQ  <= 1'b0;
            powerDownOnQ  <= 1'b0;
            clocksOnQ     <= 1'b1;
            cpuResumeQ    <= 1'b0;
            chipResetReqQ <= 1'b0;
            wakeIrqQ      <= 1'b0;
        end else begin
            stateQ        <= stateD;
            cntQ          <= cntD;
            deepSleepOnQ  <= (stateD == ST_DSLEEP);
            powerDownOnQ  <= (stateD == ST_DPD);
            clocksOnQ     <= (stateD == ST_ACTIVE) || (stateD == ST_RESTORE);
            cpuResumeQ    <= (stateQ == ST_RESTORE) && (stateD == ST_ACTIVE);
            chipResetReqQ <= (stateD == ST_RESET);
            wakeIrqQ      <= |(wStatQ & wIenQ);
        end
    end

    assign wrWord  = mergeStrb(32'h00000000, regWrData, regWrStrb);
    assign clrWord = (regWrEn && regWrAddr == `LPWG_OFF_WCLR) ? wrWord : 32'h00000000;

    // software registers, wake causes and arming flags
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlQ       <= `LPWG_RST_CTRL;
            start0Q     <= `LPWG_RST_START0;
            start1Q     <= `LPWG_RST_START1;
            cfgQ        <= `LPWG_RST_CFG;
            wStatQ      <= `LPWG_RST_WSTAT;
            wIenQ       <= `LPWG_RST_WIEN;
            wdtFedQ     <= 1'b0;
            rtcCntArmQ  <= 1'b0;
            rtcWakeArmQ <= 1'b0;
        end else begin
            if (regWrEn) begin
                case (regWrAddr)
                    `LPWG_OFF_CTRL:   ctrlQ   <= regWrStrb[0] ? regWrData[1:0] : ctrlQ;
                    `LPWG_OFF_START0: start0Q <= wrWord[8:0] | (start0Q & {{1{~regWrStrb[1]}}, {8{~regWrStrb[0]}}});
                    `LPWG_OFF_START1: start1Q <= regWrStrb[0] ? regWrData[3:0] : start1Q;
                    `LPWG_OFF_CFG:    cfgQ    <= wrWord[11:0] | (cfgQ & {{4{~regWrStrb[1]}}, {8{~regWrStrb[0]}}});
                    `LPWG_OFF_WIEN:   wIenQ   <= wrWord[11:0] | (wIenQ & {{4{~regWrStrb[1]}}, {8{~regWrStrb[0]}}});
                    default:          ctrlQ   <= ctrlQ;
                endcase
            end
            // an accepted wake ends the one-shot mode request
            if (stateQ != stateD && (stateD == ST_RESTORE || stateD == ST_RESET)) begin
                ctrlQ <= `LPWG_MODE_NONE;
            end
            wStatQ      <= causeSet | (wStatQ & ~clrWord[11:0]);
            wdtFedQ     <= sticky(wdtFedQ, wdtFeed & cfgQ[`LPWG_CF_WDTEN], ~cfgQ[`LPWG_CF_WDTEN]);
            rtcCntArmQ  <= sticky(rtcCntArmQ, rtcCountWrite, rtcAlarmS);
            rtcWakeArmQ <= sticky(rtcWakeArmQ, rtcWakeWrite, rtcWakeS);
        end
    end

    // register read mux
    always @* begin
        case (regRdAddr)
            `LPWG_OFF_CTRL:   rdData = {30'h0, ctrlQ};
            `LPWG_OFF_START0: rdData = {23'h0, start0Q};
            `LPWG_OFF_START1: rdData = {28'h0, start1Q};
            `LPWG_OFF_CFG:    rdData = {20'h0, cfgQ};
            `LPWG_OFF_STATE:  rdData = {21'h0, wdtFedQ, rtcWakeArmQ, rtcCntArmQ,
                                        5'h00, stateQ};
            `LPWG_OFF_WSTAT:  rdData = {20'h0, wStatQ};
            `LPWG_OFF_WIEN:   rdData = {20'h0, wIenQ};
            default:          rdData = 32'h00000000;
        endcase
    end

    assign deepSleepOn  = deepSleepOnQ;
    assign powerDownOn  = powerDownOnQ;
    assign clocksOn     = clocksOnQ;
    assign cpuResume    = cpuResumeQ;
    assign chipResetReq = chipResetReqQ;
    assign wakeIrq      = wakeIrqQ;
endmodule
